/* File: core/gpevt_block.sv */
// General-purpose event block: two banks of status and enable registers with byte host access
module gpevt_block #(
  parameter int BANK0_LEN_P = gpevt_pkg::BANK0_LEN,
  parameter int BANK1_LEN_P = gpevt_pkg::BANK1_LEN
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [gpevt_pkg::BANK0_LEN*4-1:0] event_bank0_i,
  input wire logic [gpevt_pkg::BANK1_LEN*4-1:0] event_bank1_i,
  input wire logic sleeping_i,
  input wire logic [gpevt_pkg::ADDR_W-1:0] host_addr_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  output logic system_control_interrupt_o,
  output logic wake_request_o
);
  import gpevt_pkg::*;

  // -------------------------------------------------------------
  // Sizes
  // -------------------------------------------------------------
  localparam int N0 = BANK0_LEN * 4;  // status bits of bank zero, half of the bank in bytes times 8
  localparam int N1 = BANK1_LEN * 4;
  localparam int NB0 = BANK0_LEN / 2;  // bytes per register
  localparam int NB1 = BANK1_LEN / 2;

  // Ports are sized from the package; the parameters only document and are checked
  if (BANK0_LEN_P != BANK0_LEN || BANK1_LEN_P != BANK1_LEN) begin : g_len_mismatch
    $error("bank lengths must match the package");
  end
  // Below two bytes a bank has no room for one status byte and one enable byte
  if (BANK0_LEN % 2 != 0 || BANK1_LEN % 2 != 0 || BANK0_LEN < 2 || BANK1_LEN < 2
      || BANK0_LEN > 4 || BANK1_LEN > 4) begin : g_len_bad
    $error("bank length must be even and fit one aligned word");
  end

  // -------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------
  logic [N0-1:0] ev0_meta;
  logic [N0-1:0] ev0_sync;
  logic [N1-1:0] ev1_meta;
  logic [N1-1:0] ev1_sync;
  logic sleep_meta;
  logic sleep_sync;

  // Event pins are asynchronous, so the first stage feeds only the second
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ev0_meta <= '0;
      ev0_sync <= '0;
      ev1_meta <= '0;
      ev1_sync <= '0;
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end else begin
      ev0_meta <= event_bank0_i;
      ev0_sync <= ev0_meta;
      ev1_meta <= event_bank1_i;
      ev1_sync <= ev1_meta;
      sleep_meta <= sleeping_i;
      sleep_sync <= sleep_meta;
    end
  end

  // -------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------
  // Bank bases are word aligned; status occupies the low half, enable the high half
  wire in_b0 = host_addr_i[ADDR_W-1:2] == BANK0_BASE[ADDR_W-1:2];
  wire in_b1 = host_addr_i[ADDR_W-1:2] == BANK1_BASE[ADDR_W-1:2];
  wire [1:0] boff = host_addr_i[1:0];
  wire b0_en_half = int'(boff) >= NB0;
  wire b1_en_half = int'(boff) >= NB1;
  wire [1:0] b0_byte = b0_en_half ? boff - 2'(NB0) : boff;
  wire [1:0] b1_byte = b1_en_half ? boff - 2'(NB1) : boff;
  wire b0_hit = in_b0 && (int'(boff) < BANK0_LEN);
  wire b1_hit = in_b1 && (int'(boff) < BANK1_LEN);

  // Byte lane mask of one register: ones at the written byte
  function automatic logic [15:0] lane_mask(input logic [1:0] idx, input logic [7:0] d);
    lane_mask = 16'({8'h00, d} << {idx, 3'b000});
  endfunction

  // Byte write strobes per register
  wire [15:0] w0_sts = (host_wr_i && b0_hit && !b0_en_half) ? lane_mask(b0_byte, host_wdata_i) : 16'h0000;
  wire [15:0] w1_sts = (host_wr_i && b1_hit && !b1_en_half) ? lane_mask(b1_byte, host_wdata_i) : 16'h0000;
  wire w0_en = host_wr_i && b0_hit && b0_en_half;
  wire w1_en = host_wr_i && b1_hit && b1_en_half;
  wire [15:0] sel0 = lane_mask(b0_byte, 8'hff);
  wire [15:0] sel1 = lane_mask(b1_byte, 8'hff);
  wire [15:0] wd0 = lane_mask(b0_byte, host_wdata_i);
  wire [15:0] wd1 = lane_mask(b1_byte, host_wdata_i);

  // -------------------------------------------------------------
  // Event banks
  // -------------------------------------------------------------
  logic [N0-1:0] event_bank0_status;
  logic [N0-1:0] event_bank0_enable;
  logic [N1-1:0] event_bank1_status;
  logic [N1-1:0] event_bank1_enable;

  // Set wins over a simultaneous write-one clear so no event is lost
  wire [N0-1:0] next_sts0 = (event_bank0_status & ~w0_sts[N0-1:0]) | ev0_sync;
  wire [N1-1:0] next_sts1 = (event_bank1_status & ~w1_sts[N1-1:0]) | ev1_sync;
  wire [N0-1:0] next_en0 = w0_en ? (event_bank0_enable & ~sel0[N0-1:0]) | wd0[N0-1:0] : event_bank0_enable;
  wire [N1-1:0] next_en1 = w1_en ? (event_bank1_enable & ~sel1[N1-1:0]) | wd1[N1-1:0] : event_bank1_enable;

  // Both banks together
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      event_bank0_status <= '0;
      event_bank0_enable <= '0;
      event_bank1_status <= '0;
      event_bank1_enable <= '0;
    end else begin
      event_bank0_status <= next_sts0;
      event_bank0_enable <= next_en0;
      event_bank1_status <= next_sts1;
      event_bank1_enable <= next_en1;
    end
  end

  // -------------------------------------------------------------
  // Interrupt and wake
  // -------------------------------------------------------------
  // Same bit position pairs status with enable inside one bank
  wire [N0-1:0] pend0 = next_sts0 & next_en0;
  wire [N1-1:0] pend1 = next_sts1 & next_en1;
  wire next_sci = |pend0 || |pend1;
  // Only rising pending bits wake, so a stale pending event cannot loop the sleeper
  wire [N0-1:0] rise0 = pend0 & ~(event_bank0_status & event_bank0_enable);
  wire [N1-1:0] rise1 = pend1 & ~(event_bank1_status & event_bank1_enable);
  wire next_wake = sleep_sync && (|rise0 || |rise1);

  // -------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------
  wire [15:0] rv0 = 16'(b0_en_half ? event_bank0_enable : event_bank0_status) >> {b0_byte, 3'b000};
  wire [15:0] rv1 = 16'(b1_en_half ? event_bank1_enable : event_bank1_status) >> {b1_byte, 3'b000};
  // Unmapped bytes read as zero
  wire [7:0] next_rdata = !host_rd_i ? BYTE_ZERO : b0_hit ? rv0[7:0] : b1_hit ? rv1[7:0] : BYTE_ZERO;

  // Registered outputs
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      host_rdata_o <= RESET_BYTE;
      system_control_interrupt_o <= 1'b0;
      wake_request_o <= 1'b0;
    end else begin
      host_rdata_o <= next_rdata;
      system_control_interrupt_o <= next_sci;
      wake_request_o <= next_wake;
    end
  end

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  // Bits that must survive a cycle, and bits that a write of one must clear
  wire [N0-1:0] keep0 = event_bank0_status & ~w0_sts[N0-1:0];
  wire [N1-1:0] keep1 = event_bank1_status & ~w1_sts[N1-1:0];
  wire [N0-1:0] clr0 = w0_sts[N0-1:0] & ~ev0_sync;
  wire [N1-1:0] clr1 = w1_sts[N1-1:0] & ~ev1_sync;

  property p_sts_set;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (|ev0_sync) |=> (event_bank0_status & $past(ev0_sync)) == $past(ev0_sync);
  endproperty
  a_sts_set: assert property (p_sts_set) else $error("active event did not set status");

  property p_sts_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (|keep0) |=> (event_bank0_status & $past(keep0)) == $past(keep0);
  endproperty
  a_sts_hold: assert property (p_sts_hold) else $error("status cleared without write one");

  // A clear is only checked for bits whose pin is idle, since the set wins otherwise
  property p_sts_clear;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (|clr0) |=> (event_bank0_status & $past(clr0)) == '0;
  endproperty
  a_sts_clear: assert property (p_sts_clear) else $error("write one did not clear status");

  // Bank one follows the same set, hold and clear rules
  property p_b1_sts_set;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (|ev1_sync) |=> (event_bank1_status & $past(ev1_sync)) == $past(ev1_sync);
  endproperty
  a_b1_sts_set: assert property (p_b1_sts_set) else $error("bank one event did not set status");

  property p_b1_sts_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (|keep1) |=> (event_bank1_status & $past(keep1)) == $past(keep1);
  endproperty
  a_b1_sts_hold: assert property (p_b1_sts_hold) else $error("bank one status cleared without write one");

  property p_b1_sts_clear;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (|clr1) |=> (event_bank1_status & $past(clr1)) == '0;
  endproperty
  a_b1_sts_clear: assert property (p_b1_sts_clear) else $error("bank one write one did not clear");

  property p_sci;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      system_control_interrupt_o == (|(event_bank0_status & event_bank0_enable)
      || |(event_bank1_status & event_bank1_enable));
  endproperty
  a_sci: assert property (p_sci) else $error("interrupt does not follow pending bits");

  property p_sync;
    @(posedge sys_clk_i) disable iff (!nrst_i) $rose(event_bank1_i[0]) ##1 event_bank1_i[0] |=> ev1_sync[0];
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser latency wrong");

  property p_wake_sleep;
    @(posedge sys_clk_i) disable iff (!nrst_i) wake_request_o |-> $past(sleep_sync);
  endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake raised while awake");

  property p_en_write;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      host_wr_i && in_b1 && host_addr_i[1:0] == 2'(NB1) |=> event_bank1_enable[7:0] == $past(host_wdata_i);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable byte write lost");

  property p_rd_status;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      host_rd_i && in_b0 && host_addr_i[1:0] == 2'b00 |=> host_rdata_o == $past(event_bank0_status[7:0]);
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status byte read wrong");

  // Enable bits move only on a host write to one of their own bytes
  property p_en_hold0;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !w0_en |=> $stable(event_bank0_enable);
  endproperty
  a_en_hold0: assert property (p_en_hold0) else $error("bank zero enable changed without a write");

  property p_en_hold1;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !w1_en |=> $stable(event_bank1_enable);
  endproperty
  a_en_hold1: assert property (p_en_hold1) else $error("bank one enable changed without a write");

  property p_b0_en_write;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      host_wr_i && in_b0 && host_addr_i[1:0] == 2'(NB0) |=> event_bank0_enable[7:0] == $past(host_wdata_i);
  endproperty
  a_b0_en_write: assert property (p_b0_en_write) else $error("bank zero enable byte write lost");

  // A wake only ever comes with a pending interrupt behind it
  property p_wake_pend;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      wake_request_o |-> system_control_interrupt_o;
  endproperty
  a_wake_pend: assert property (p_wake_pend) else $error("wake raised with nothing pending");

  // Read data is registered: each read answers on the next edge and idles at zero
  property p_rd_idle;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !host_rd_i |=> host_rdata_o == BYTE_ZERO;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero without a read");

  property p_rd_unmapped;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      host_rd_i && !b0_hit && !b1_hit |=> host_rdata_o == BYTE_ZERO;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped byte read not zero");

  property p_rd_status1;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      host_rd_i && in_b1 && host_addr_i[1:0] == 2'b00 |=> host_rdata_o == $past(event_bank1_status[7:0]);
  endproperty
  a_rd_status1: assert property (p_rd_status1) else $error("bank one status byte read wrong");

  property p_rd_enable1;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      host_rd_i && in_b1 && host_addr_i[1:0] == 2'(NB1) |=> host_rdata_o == $past(event_bank1_enable[7:0]);
  endproperty
  a_rd_enable1: assert property (p_rd_enable1) else $error("bank one enable byte read wrong");
endmodule

/* File: core/gpevt_pkg.sv */
// Package with the constants of the general-purpose event block
package gpevt_pkg;
  // Byte lengths of each bank (status half plus enable half)
  localparam int BANK0_LEN = 4;
  localparam int BANK1_LEN = 4;
  // Bank bases inside the block's byte window, each word aligned
  localparam logic [3:0] BANK0_BASE = 4'h0;
  localparam logic [3:0] BANK1_BASE = 4'h4;
  localparam int ADDR_W = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

/* File: tb/gpevt_event_src.sv */
// Platform event sources that drive the event pins of both banks
module gpevt_event_src #(
  parameter logic [15:0] USED_P = 16'h7fff
) (
  input wire logic sys_clk_i,
  input wire logic [gpevt_pkg::BANK0_LEN*4-1:0] req0_i,
  input wire logic [gpevt_pkg::BANK1_LEN*4-1:0] req1_i,
  output logic [gpevt_pkg::BANK0_LEN*4-1:0] pin0_o,
  output logic [gpevt_pkg::BANK1_LEN*4-1:0] pin1_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpevt_pkg::*;
  // Pins start inactive so nothing floats into the synchronisers; one pin per event,
  // and unwired pins are held low so they can never set a status bit
  initial begin
    pin0_o = '0;
    pin1_o = '0;
    forever begin
      @(negedge sys_clk_i);
      pin0_o <= req0_i & USED_P;
      pin1_o <= req1_i & USED_P;
    end
  end
endmodule

/* File: tb/gpevt_block_tb_top.sv */
// Self-checking testbench for the general-purpose event block
module gpevt_block_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gpevt_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sleep = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [15:0] req0 = 16'h0000;
  logic [15:0] req1 = 16'h0000;
  wire logic [15:0] pin0;
  wire logic [15:0] pin1;
  wire logic [7:0] rdata;
  wire logic irq;
  wire logic wake;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int wakes = 0;
  gpevt_event_src src (.sys_clk_i(clk), .req0_i(req0), .req1_i(req1), .pin0_o(pin0), .pin1_o(pin1));
  gpevt_block dut (.sys_clk_i(clk), .nrst_i(nrst), .event_bank0_i(pin0), .event_bank1_i(pin1),
    .sleeping_i(sleep), .host_addr_i(addr), .host_rd_i(rd), .host_wr_i(wr), .host_wdata_i(wdata),
    .host_rdata_o(rdata), .system_control_interrupt_o(irq), .wake_request_o(wake));
  // ----------------------------------------
  // Clock, hang guard and shared tasks
  // ----------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end
  // A hang is cut off well past the under two hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Flags are compared apart from bytes so an unknown flag never matches
  task automatic check1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_byte(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Read data is registered at the taking edge and looked at half a cycle later
  task automatic rd_byte(input logic [3:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check8(rdata, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic count_wakes();
    wakes = 0;
    repeat (10) begin
      @(negedge clk);
      if (wake !== 1'b0) wakes++;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    idle(6);
    nrst = 1'b1;
    for (int a = 0; a < 16; a++) rd_byte(a[3:0], RESET_BYTE);
    wr_byte(4'h2, 8'ha5);
    wr_byte(4'h6, 8'h3c);
    wr_byte(4'h9, 8'hff);
    rd_byte(4'h2, 8'ha5);
    rd_byte(4'h6, 8'h3c);
    rd_byte(4'h9, 8'h00);
    wr_byte(4'h2, 8'h00);
    wr_byte(4'h6, 8'h00);
    // Pins raise status; zero writes and set-wins leave it alone
    req0 = 16'h0108;
    idle(5);
    rd_byte(4'h0, 8'h08);
    rd_byte(4'h1, 8'h01);
    wr_byte(4'h0, 8'h00);
    rd_byte(4'h0, 8'h08);
    wr_byte(4'h0, 8'h08);
    rd_byte(4'h0, 8'h08);
    wr_byte(4'h3, 8'h02);
    idle(2);
    check1(irq, 1'b0);
    wr_byte(4'h3, 8'h01);
    idle(2);
    check1(irq, 1'b1);
    req0 = 16'h0000;
    idle(5);
    wr_byte(4'h0, 8'h08);
    rd_byte(4'h0, 8'h00);
    rd_byte(4'h1, 8'h01);
    idle(1);
    check1(irq, 1'b1);
    wr_byte(4'h1, 8'h01);
    idle(2);
    check1(irq, 1'b0);
    // Wake only while asleep, for an enabled bit of bank one
    wr_byte(4'h7, 8'h04);
    sleep = 1'b1;
    idle(4);
    req1 = 16'h0400;
    count_wakes();
    check8(wakes[7:0], 8'h01);
    check1(irq, 1'b1);
    rd_byte(4'h5, 8'h04);
    sleep = 1'b0;
    wr_byte(4'h7, 8'h0c);
    idle(4);
    req1 = 16'h0c00;
    count_wakes();
    check8(wakes[7:0], 8'h00);
    check1(wake, 1'b0);
    // Idle pins let a write of one clear bank one; a live pin wins over the clear
    req1 = 16'h0001;
    idle(5);
    wr_byte(4'h5, 8'h0c);
    rd_byte(4'h5, 8'h00);
    wr_byte(4'h4, 8'h01);
    rd_byte(4'h4, 8'h01);
    wr_byte(4'h6, 8'h01);
    idle(1);
    check1(irq, 1'b1);
    // A second reset mid-run wipes every register and drops the interrupt
    req1 = 16'h0000;
    nrst = 1'b0;
    idle(2);
    check1(irq, 1'b0);
    nrst = 1'b1;
    for (int a = 0; a < 8; a++) rd_byte(a[3:0], RESET_BYTE);
    check1(irq, 1'b0);
    conclude();
  end
endmodule
